//--- hdl/crm_map.vh
/*
 * Constants for the small processor core: flag bit positions, opcodes,
 * reset values and the mode-3 control register window.
 * Assumes it is included by its bare name from the core file.
 */
`ifndef CRM_MAP_VH
`define CRM_MAP_VH

// Flag register bit positions.
`define CRM_FLAG_C 0
`define CRM_FLAG_V 1
`define CRM_FLAG_Z 2
`define CRM_FLAG_N 3
`define CRM_FLAG_I 4
`define CRM_FLAG_H 5
// Upper two flag bits always read as ones.
`define CRM_FLAG_ONES 8'hC0
// Flag register value after reset: interrupt mask set.
`define CRM_FLAG_RST 8'hD0
// Reset values of the pointer registers.
`define CRM_PC_RST 16'h0000
`define CRM_SP_RST 16'h00FF
// Inherent opcodes.
`define CRM_OP_NOP 8'h01
`define CRM_OP_TAP 8'h06
`define CRM_OP_TPA 8'h07
`define CRM_OP_INX 8'h08
`define CRM_OP_DEX 8'h09
`define CRM_OP_CLI 8'h0E
`define CRM_OP_SEI 8'h0F
`define CRM_OP_TAB 8'h16
`define CRM_OP_TBA 8'h17
`define CRM_OP_DAA 8'h19
`define CRM_OP_ABA 8'h1B
`define CRM_OP_TSX 8'h30
`define CRM_OP_TXS 8'h35
`define CRM_OP_ABX 8'h3A
// Branch opcodes occupy 20..2F.
`define CRM_OP_BR_HI 4'h2
// Load opcodes per addressing mode.
`define CRM_OP_LDAA_IMM 8'h86
`define CRM_OP_LDAA_DIR 8'h96
`define CRM_OP_LDAA_IDX 8'hA6
`define CRM_OP_LDAA_EXT 8'hB6
`define CRM_OP_LDX_IMM 8'hCE
`define CRM_OP_LDD_IMM 8'hCC
// Control register window reached by direct addresses below this limit.
`define CRM_CTRL_LIMIT 8'h20
`define CRM_MODE3 3'h3

`endif

//--- hdl/crm_core.v
/*
 * Register model and operand addressing of an 8-bit processor core.
 * Holds the accumulators, pointers and flags, fetches instructions over a
 * simple one-cycle read bus and executes a representative instruction set:
 * loads in the four memory modes, branches, pointer moves and decimal adjust.
 * Assumes memory answers every read within the same cycle in which the address is shown.
 */
// How it works
// - A and B form D, A high.
// - 16-bit PC addresses next instruction.
// - 16-bit SP points to next free slot.
// - 16-bit X holds data or index base.
// - Flags H,I,N,Z,V,C; I in bit four.
// - Flag bits six and seven read one.
// - Direct address high byte is zero.
// - Mode 3 direct skips control registers.
// - Extended takes 16-bit address from two bytes.
// - Indexed adds unsigned offset, X unchanged.
// - Taken branch adds signed displacement to PC.
// - Immediate operand one or two bytes.
// - Inherent ops one byte, no memory.
// - Index to stack minus one, reverse plus one.
// - Decimal adjust corrects A to BCD.
`timescale 1ns/1ps
`default_nettype none
`include "crm_map.vh"

module crm_core (
    input wire clk, // System clock, 100 MHz.
    input wire rst, // Asynchronous reset, active high.
    input wire [2:0] op_mode, // Operating mode select.
    input wire [7:0] mem_rdata, // Read data from memory.
    output reg [15:0] mem_addr, // Memory address.
    output reg mem_rd, // Memory read strobe.
    output reg ctrl_sel, // Access aimed at control registers.
    output reg [7:0] acc_a, // Accumulator A.
    output reg [7:0] acc_b, // Accumulator B.
    output reg [15:0] pc_out, // Program counter.
    output reg [15:0] sp_out, // Stack pointer.
    output reg [15:0] ix_out, // Index register.
    output reg [7:0] flag_register // Flag register as read.
);

    // Sequencer states.
    localparam ST_FETCH = 3'd0;
    localparam ST_OP1 = 3'd1;
    localparam ST_OP2 = 3'd2;
    localparam ST_MEM = 3'd3;
    localparam ST_MEM2 = 3'd4;

    reg [2:0] state_reg; // Current state.
    reg [7:0] opc_reg; // Opcode being executed.
    reg [7:0] b2_reg; // Second instruction byte.
    reg [15:0] ea_reg; // Effective operand address.
    reg [5:0] flg_reg; // Six live flag bits.

    // Applies decimal correction to a binary sum held in A.
    function [8:0] dec_adj;
        input [7:0] a;
        input hc;
        input cy;
        reg [7:0] corr;
        reg hi;
        begin
            corr = 8'h00;
            hi = cy;
            if (hc || (a[3:0] > 4'h9)) begin
                corr[3:0] = 4'h6;
            end
            if (cy || (a[7:4] > 4'h9) || ((a[7:4] > 4'h8) && (a[3:0] > 4'h9))) begin
                corr[7:4] = 4'h6;
                hi = 1'b1;
            end
            dec_adj = {hi, a + corr};
        end
    endfunction

    // Branch condition test from the low nibble of a 2x opcode.
    function br_take;
        input [3:0] cond;
        input [5:0] f;
        reg t;
        begin
            case (cond[3:1])
                3'd0: t = 1'b1;
                3'd1: t = ~(f[`CRM_FLAG_C] | f[`CRM_FLAG_Z]);
                3'd2: t = ~f[`CRM_FLAG_C];
                3'd3: t = ~f[`CRM_FLAG_Z];
                3'd4: t = ~f[`CRM_FLAG_V];
                3'd5: t = ~f[`CRM_FLAG_N];
                3'd6: t = ~(f[`CRM_FLAG_N] ^ f[`CRM_FLAG_V]);
                default: t = ~(f[`CRM_FLAG_Z] | (f[`CRM_FLAG_N] ^ f[`CRM_FLAG_V]));
            endcase
            br_take = cond[0] ? ~t : t;
        end
    endfunction

    // Sets N and Z from an 8-bit result, clears V.
    function [5:0] nz8;
        input [5:0] f;
        input [7:0] r;
        begin
            nz8 = f;
            nz8[`CRM_FLAG_N] = r[7];
            nz8[`CRM_FLAG_Z] = (r == 8'h00);
            nz8[`CRM_FLAG_V] = 1'b0;
        end
    endfunction

    wire [8:0] daa_res = dec_adj(acc_a, flg_reg[`CRM_FLAG_H], flg_reg[`CRM_FLAG_C]);
    wire [8:0] add_lo = {1'b0, acc_a} + {1'b0, acc_b};
    wire [4:0] add_h = {1'b0, acc_a[3:0]} + {1'b0, acc_b[3:0]};
    wire [15:0] pc_inc = pc_out + 16'h0001;
    wire [15:0] br_dest = pc_inc + {{8{mem_rdata[7]}}, mem_rdata};
    wire [15:0] idx_ea = ix_out + {8'h00, mem_rdata};
    wire is_mem = (opc_reg == `CRM_OP_LDAA_DIR) || (opc_reg == `CRM_OP_LDAA_IDX) ||
        (opc_reg == `CRM_OP_LDAA_EXT);

    // Main sequencer: fetch, operand bytes, memory access, execute.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_FETCH;
            opc_reg <= 8'h00;
            b2_reg <= 8'h00;
            ea_reg <= 16'h0000;
            flg_reg <= 6'h10;
            acc_a <= 8'h00;
            acc_b <= 8'h00;
            pc_out <= `CRM_PC_RST;
            sp_out <= `CRM_SP_RST;
            ix_out <= 16'h0000;
            mem_addr <= `CRM_PC_RST;
            mem_rd <= 1'b1;
            ctrl_sel <= 1'b0;
            flag_register <= `CRM_FLAG_RST;
        end else begin
            flag_register <= `CRM_FLAG_ONES | {2'b00, flg_reg};
            ctrl_sel <= 1'b0;
            mem_rd <= 1'b1;
            case (state_reg)
                // Opcode arrives; decide what follows.
                ST_FETCH: begin
                    opc_reg <= mem_rdata;
                    pc_out <= pc_inc;
                    mem_addr <= pc_inc;
                    if ((mem_rdata[7:4] == `CRM_OP_BR_HI) ||
                        (mem_rdata[7] && (mem_rdata[3:0] != 4'h7))) begin
                        state_reg <= ST_OP1;
                    end else begin
                        // Inherent: single byte, no operand access.
                        state_reg <= ST_FETCH;
                        case (mem_rdata)
                            `CRM_OP_TAP: flg_reg <= acc_a[5:0];
                            `CRM_OP_TPA: acc_a <= `CRM_FLAG_ONES | {2'b00, flg_reg};
                            `CRM_OP_INX: ix_out <= ix_out + 16'h0001;
                            `CRM_OP_DEX: ix_out <= ix_out - 16'h0001;
                            `CRM_OP_CLI: flg_reg[`CRM_FLAG_I] <= 1'b0;
                            `CRM_OP_SEI: flg_reg[`CRM_FLAG_I] <= 1'b1;
                            `CRM_OP_TAB: begin
                                acc_b <= acc_a;
                                flg_reg <= nz8(flg_reg, acc_a);
                            end
                            `CRM_OP_TBA: begin
                                acc_a <= acc_b;
                                flg_reg <= nz8(flg_reg, acc_b);
                            end
                            `CRM_OP_ABA: begin
                                acc_a <= add_lo[7:0];
                                flg_reg <= {add_h[4], flg_reg[4], add_lo[7], add_lo[7:0] == 8'h00,
                                    (acc_a[7] == acc_b[7]) && (add_lo[7] != acc_a[7]), add_lo[8]};
                            end
                            `CRM_OP_DAA: begin
                                acc_a <= daa_res[7:0];
                                flg_reg[`CRM_FLAG_C] <= daa_res[8];
                                flg_reg[`CRM_FLAG_N] <= daa_res[7];
                                flg_reg[`CRM_FLAG_Z] <= (daa_res[7:0] == 8'h00);
                            end
                            `CRM_OP_TXS: sp_out <= ix_out - 16'h0001;
                            `CRM_OP_TSX: ix_out <= sp_out + 16'h0001;
                            `CRM_OP_ABX: ix_out <= ix_out + {8'h00, acc_b};
                            default: state_reg <= ST_FETCH;
                        endcase
                    end
                end
                // Second byte: operand, displacement, offset or address.
                ST_OP1: begin
                    b2_reg <= mem_rdata;
                    pc_out <= pc_inc;
                    mem_addr <= pc_inc;
                    state_reg <= ST_FETCH;
                    if (opc_reg[7:4] == `CRM_OP_BR_HI) begin
                        if (br_take(opc_reg[3:0], flg_reg)) begin
                            pc_out <= br_dest;
                            mem_addr <= br_dest;
                        end
                    end else if (opc_reg == `CRM_OP_LDAA_IMM) begin
                        acc_a <= mem_rdata;
                        flg_reg <= nz8(flg_reg, mem_rdata);
                    end else if (opc_reg == `CRM_OP_LDX_IMM || opc_reg == `CRM_OP_LDD_IMM ||
                        opc_reg == `CRM_OP_LDAA_EXT) begin
                        state_reg <= ST_OP2; // Three-byte form.
                    end else if (opc_reg == `CRM_OP_LDAA_DIR) begin
                        ea_reg <= {8'h00, mem_rdata};
                        mem_addr <= {8'h00, mem_rdata};
                        ctrl_sel <= (op_mode != `CRM_MODE3) && (mem_rdata < `CRM_CTRL_LIMIT);
                        state_reg <= ST_MEM;
                    end else if (opc_reg == `CRM_OP_LDAA_IDX) begin
                        ea_reg <= idx_ea;
                        mem_addr <= idx_ea;
                        state_reg <= ST_MEM;
                    end
                end
                // Third byte: low half of a 16-bit operand or address.
                ST_OP2: begin
                    pc_out <= pc_inc;
                    mem_addr <= pc_inc;
                    state_reg <= ST_FETCH;
                    if (opc_reg == `CRM_OP_LDX_IMM) begin
                        ix_out <= {b2_reg, mem_rdata};
                        flg_reg <= nz8(flg_reg, b2_reg | mem_rdata);
                        flg_reg[`CRM_FLAG_N] <= b2_reg[7];
                    end else if (opc_reg == `CRM_OP_LDD_IMM) begin
                        acc_a <= b2_reg;
                        acc_b <= mem_rdata;
                        flg_reg <= nz8(flg_reg, b2_reg | mem_rdata);
                        flg_reg[`CRM_FLAG_N] <= b2_reg[7];
                    end else begin
                        ea_reg <= {b2_reg, mem_rdata};
                        mem_addr <= {b2_reg, mem_rdata};
                        state_reg <= ST_MEM;
                    end
                end
                // Operand address is on the bus; data is already valid but is taken next cycle.
                ST_MEM: begin
                    mem_addr <= ea_reg;
                    state_reg <= ST_MEM2;
                end
                // Operand data is taken into A; resume fetch at the PC.
                ST_MEM2: begin
                    if (is_mem) begin
                        acc_a <= mem_rdata;
                        flg_reg <= nz8(flg_reg, mem_rdata);
                    end
                    mem_addr <= pc_out;
                    state_reg <= ST_FETCH;
                end
                default: state_reg <= ST_FETCH;
            endcase
        end
    end

endmodule // crm_core
`default_nettype wire

//--- test/crm_mem_model.sv
/* Behavioural program and data memory on the core's read bus.
   Assumes the bench writes program bytes into mem while the core is held in reset. */
`timescale 1ns/1ps
`default_nettype none
module crm_mem_model (
    input wire logic clk, // Core clock.
    input wire logic [15:0] mem_addr, // Address from the core.
    input wire logic mem_rd, // Read strobe.
    output logic [7:0] mem_rdata // Read data.
);
    logic [7:0] mem [0:65535]; // Whole address space.
    logic junk; // Toggles so a bus that is not read never looks stable.
    // Bytes below C0 execute as no-ops; elsewhere each byte is a hash of its address.
    initial begin
        junk = 1'b0;
        for (int i = 0; i < 65536; i++) mem[i] = (i < 192) ? 8'h01 : 8'(i ^ (i >> 8) ^ 8'h5A);
    end
    // The toggle costs nothing and stops a stale byte passing for a real one.
    always @(posedge clk) begin
        junk <= ~junk;
    end
    // No wait states: data stands for as long as the address does.
    assign mem_rdata = mem_rd ? mem[mem_addr] : {8{junk}};
endmodule // crm_mem_model
`default_nettype wire

//--- test/crm_core_checker.sv
/* Concurrent checks on the core's ports.
   Assumes one clock domain and the asynchronous active-high reset rst. */
`timescale 1ns/1ps
`default_nettype none
module crm_core_checker (
    input wire logic clk, // Core clock.
    input wire logic rst, // Reset, active high.
    input wire logic [2:0] op_mode, // Operating mode.
    input wire logic [7:0] mem_rdata, // Memory read data.
    input wire logic [15:0] mem_addr, // Memory address.
    input wire logic mem_rd, // Read strobe.
    input wire logic ctrl_sel, // Control register access flag.
    input wire logic [7:0] acc_a, // Accumulator A.
    input wire logic [7:0] acc_b, // Accumulator B.
    input wire logic [15:0] pc_out, // Program counter.
    input wire logic [15:0] sp_out, // Stack pointer.
    input wire logic [15:0] ix_out, // Index register.
    input wire logic [7:0] flag_register // Flags as read.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A direct operand address stands a second cycle with the flag gone.
    sequence direct_hold;
        !ctrl_sel && $stable(mem_addr);
    endsequence
    flag_ones_a: assert property (flag_register[7:6] == 2'b11)
        else $error("flag bits 7 and 6 not set");
    dir_form_a: assert property (ctrl_sel |-> mem_addr == {8'h00, $past(mem_rdata)})
        else $error("direct address not zero page of byte two");
    dir_window_a: assert property (ctrl_sel |-> mem_addr < 16'h0020)
        else $error("control access outside window");
    dir_hold_a: assert property (ctrl_sel |=> direct_hold)
        else $error("direct address did not stand");
    mode3_block_a: assert property (ctrl_sel |-> $past(op_mode) != 3'h3)
        else $error("control access in mode 3");
    sp_from_ix_a: assert property (sp_out != $past(sp_out) |-> sp_out == $past(ix_out) - 16'h0001)
        else $error("stack pointer moved other than index minus one");
    pc_step_a: assert property (16'(pc_out - $past(pc_out) + 16'h007F) <= 16'h00FF)
        else $error("program counter jumped out of range");
    read_only_a: assert property (mem_rd)
        else $error("read strobe dropped");
endmodule // crm_core_checker
bind crm_core crm_core_checker u_chk (.clk(clk), .rst(rst), .op_mode(op_mode), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .ctrl_sel(ctrl_sel), .acc_a(acc_a), .acc_b(acc_b),
    .pc_out(pc_out), .sp_out(sp_out), .ix_out(ix_out), .flag_register(flag_register));
`default_nettype wire

//--- test/testbench.sv
/* Self-checking bench: loads a program touching every addressing mode, runs it, checks registers.
   Assumes the core and crm_mem_model; expected values come from the bench's own functions. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0; // 100 MHz clock.
    logic rst = 1'b1; // Reset, active high.
    logic [2:0] op_mode = 3'h0; // Operating mode.
    logic [7:0] mem_rdata, acc_a, acc_b, flag_register; // Core outputs and read data.
    logic [15:0] mem_addr, pc_out, sp_out, ix_out; // Core addresses and pointers.
    logic mem_rd, ctrl_sel; // Strobes.
    int error_cnt = 0, compares = 0, ctrl_cnt = 0; // Counters.
    always #5 clk = ~clk;
    crm_core u_dut (.clk(clk), .rst(rst), .op_mode(op_mode), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .ctrl_sel(ctrl_sel), .acc_a(acc_a), .acc_b(acc_b), .pc_out(pc_out),
        .sp_out(sp_out), .ix_out(ix_out), .flag_register(flag_register));
    crm_mem_model u_mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
    // Count control register accesses of the current run; every reset clears the count.
    always @(posedge clk) begin
        if (rst === 1'b1) ctrl_cnt = 0;
        else if (ctrl_sel === 1'b1) ctrl_cnt++;
    end
    // Memory contents as the bench expects them outside the program page.
    function automatic logic [7:0] pat(input logic [15:0] a);
        return (a < 16'h00C0) ? 8'h01 : (a[7:0] ^ a[15:8] ^ 8'h5A);
    endfunction
    // Packed decimal sum modulo one hundred.
    function automatic logic [7:0] bcd_add(input logic [7:0] p, input logic [7:0] q);
        int s;
        s = (p[7:4] * 10 + p[3:0] + q[7:4] * 10 + q[3:0]) % 100;
        return {4'(s / 10), 4'(s % 10)};
    endfunction
    // Flags after adding q to p: H, I (still set from reset), N, Z, V, C.
    function automatic logic [5:0] add_flags(input logic [7:0] p, input logic [7:0] q);
        int u, sv;
        u = int'(p) + int'(q);
        sv = int'($signed(p)) + int'($signed(q));
        return {int'(p[3:0]) + int'(q[3:0]) > 15, 1'b1, u[7], u[7:0] == 0, sv > 127 || sv < -128, u > 255};
    endfunction
    // Outcome of a 2x branch for its low nibble, flags packed H, I, N, Z, V, C.
    function automatic logic br_ok(input logic [3:0] cc, input logic [5:0] f);
        logic n, z, v, c;
        n = f[3];
        z = f[2];
        v = f[1];
        c = f[0];
        case (cc)
            4'h0: return 1'b1;
            4'h1: return 1'b0;
            4'h2: return !(c || z);
            4'h3: return c || z;
            4'h4: return !c;
            4'h5: return c;
            4'h6: return !z;
            4'h7: return z;
            4'h8: return !v;
            4'h9: return v;
            4'hA: return !n;
            4'hB: return n;
            4'hC: return n == v;
            4'hD: return n != v;
            4'hE: return !z && n == v;
            default: return z || n != v;
        endcase
    endfunction
    function automatic logic [7:0] rbcd();
        return {4'($urandom % 10), 4'($urandom % 10)};
    endfunction
    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One program run; a conditional branch skips two index increments when taken,
    // the mask is set or cleared from r, and the final branch lands on a self-loop at t.
    task automatic run(input logic [15:0] x, d, e, input logic [7:0] a1, a2, off, c, dd, r, input logic [2:0] md);
        logic [7:0] prog [$];
        logic [15:0] xs, x2, t;
        logic [7:0] me, mi;
        logic [5:0] fl;
        logic tk;
        xs = x + d[7:0] + d[15:8];
        x2 = xs + bcd_add(a1, a2);
        t = 16'h0028 + r;
        me = pat(e);
        mi = pat(x2 + off);
        fl = add_flags(pat({8'h00, dd}), 8'(me + mi));
        tk = br_ok(r[3:0], fl);
        prog = '{8'hCE, x[15:8], x[7:0], 8'hCC, d[15:8], d[7:0], 8'h3A, 8'h16, 8'h3A, 8'h35, 8'h86, a1, 8'h16,
            8'h86, a2, 8'h1B, 8'h19, 8'h16, 8'h3A, 8'hB6, e[15:8], e[7:0], 8'h16, 8'hA6, off, 8'h1B, 8'h16,
            8'h96, c, 8'h96, dd, 8'h1B, 8'h30, {4'h2, r[3:0]}, 8'h02, 8'h08, 8'h08, {7'h07, r[4]}, 8'h20, r};
        @(posedge clk) #1;
        rst = 1'b1;
        op_mode = md;
        foreach (prog[i]) u_mem.mem[i] = prog[i];
        u_mem.mem[t] = 8'h20;
        u_mem.mem[t + 16'h0001] = 8'hFE;
        repeat (5) @(posedge clk);
        cmp(pc_out, 16'h0000);
        cmp(sp_out, 16'h00FF);
        cmp(ix_out, 16'h0000);
        cmp(flag_register, 16'h00D0);
        #1 rst = 1'b0;
        for (int k = 0; k < 400 && pc_out !== t; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1 cmp({15'h0000, (pc_out === t) || (pc_out === t + 16'h0001)}, 16'h0001);
        cmp(acc_a, 8'(pat({8'h00, dd}) + me + mi));
        cmp(acc_b, 8'(me + mi));
        cmp(ix_out, tk ? xs : xs + 16'h0002);
        cmp(flag_register, {8'h00, 2'b11, fl[5], r[4], fl[3:0]});
        cmp(sp_out, xs - 16'h0001);
        cmp(16'(ctrl_cnt), (md != 3'h3) ? 16'h0001 : 16'h0000);
    endtask
    // Corner cases first: carries everywhere, longest branch, then shortest branch at window edge.
    initial begin
        void'($urandom(80560));
        run(16'h04FF, 16'hFFFF, 16'h02FF, 8'h99, 8'h99, 8'hFF, 8'h1F, 8'hFF, 8'h7F, 3'h3);
        run(16'h0400, 16'h0000, 16'h0200, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 3'h0);
        repeat (6) run({8'h04, 8'($urandom)}, 16'($urandom), {8'h02, 8'($urandom)}, rbcd(), rbcd(),
            8'($urandom), 8'($urandom % 32), {2'b11, 6'($urandom)}, 8'($urandom % 128), 3'($urandom));
        end_sim();
    end
    // A hang counts as a mismatch.
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
